/* rsl_consts.svh */
// named constants of the rail state and fault logger
// assumes inclusion by bare name from the package, the logger, the checker and the bench
`ifndef RSL_CONSTS_SVH
`define RSL_CONSTS_SVH

// reported rail state codes
`define RSL_CODE_INACTIVE 4'h1
`define RSL_CODE_AWAIT_ON 4'h2
`define RSL_CODE_ON_DELAY 4'h3
`define RSL_CODE_RISING 4'h4
`define RSL_CODE_REGULATED 4'h5
`define RSL_CODE_AWAIT_OFF 4'h6
`define RSL_CODE_OFF_DELAY 4'h7
`define RSL_CODE_FALLING 4'h8

// register indices on the plain register port
`define RSL_A_STATE 7'h00
`define RSL_N_STATE 7'h04
`define RSL_A_FLT 7'h08
`define RSL_N_FLT 7'h08
`define RSL_A_RTC 7'h10
`define RSL_A_RSTCNT 7'h11
`define RSL_A_SNAP 7'h12
`define RSL_A_BUSADDR 7'h13
`define RSL_A_PEAK 7'h20
`define RSL_A_VOLT 7'h40

// snapshot control / status bit positions
`define RSL_SNAP_TAKEN_BIT 0
`define RSL_SNAP_LOST_BIT 1
`define RSL_SNAP_BUSY_BIT 2

// target addresses picked by the three address pins
`define RSL_TADDR_0 7'h11
`define RSL_TADDR_1 7'h13
`define RSL_TADDR_2 7'h17
`define RSL_TADDR_3 7'h31
`define RSL_TADDR_4 7'h33
`define RSL_TADDR_5 7'h71
`define RSL_TADDR_6 7'h73
`define RSL_TADDR_7 7'h77

// timing
`define RSL_CLK_HZ 125000000
`define RSL_PEAK_HOLD_S 30
`define RSL_RTC_TICK_US 1000
`define RSL_US_PER_S 1000000

`endif

/* rsl_ee_model.sv */
// eeprom writer stand-in: takes log records and counts them per kind
// assumes the logger's record handshake on the shared reference clock
`timescale 1ns/1ps
module rsl_ee_model (
    // clock and pacing
    input wire logic ref_clk,
    input wire logic slow,
    // record handshake
    input wire logic ee_wr_valid,
    input wire rsl_pkg::rsl_rec_type ee_wr_kind,
    input wire logic [63:0] ee_wr_data,
    output logic ee_wr_ready
);
    int cnt [8]; // accepted records per kind
    logic [63:0] last [8]; // payload of the latest record per kind
    logic [1:0] phase; // stall pattern counter
    initial begin
        foreach (cnt[i]) cnt[i] = 0;
        phase = 2'h0;
        ee_wr_ready = 1'b0;
    end
    // slow mode: ready one cycle in four
    always @(posedge ref_clk) begin
        phase <= phase + 2'h1;
        ee_wr_ready <= !slow || (phase == 2'h3);
        if (ee_wr_valid && ee_wr_ready) begin
            cnt[ee_wr_kind] <= cnt[ee_wr_kind] + 1;
            last[ee_wr_kind] <= ee_wr_data;
        end
    end
endmodule // rsl_ee_model

/* rsl_logger.sv */
// rail state tracking, status registers and nonvolatile event logging
// assumes a sequencing engine supplies per-rail condition levels, a
// measurement stream, fault pulses and an eeprom writer with ready
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "rsl_consts.svh"

module rsl_logger #(
    parameter int NUM_RAILS = 32,
    parameter int NUM_ANALOG = 24,
    parameter int IO_W = 84,
    parameter logic [31:0] PEAK_HOLD_CYC =
        32'(64'(`RSL_PEAK_HOLD_S) * 64'(`RSL_CLK_HZ)),
    parameter logic [31:0] RTC_TICK_CYC =
        32'(64'(`RSL_RTC_TICK_US) * 64'(`RSL_CLK_HZ) / 64'(`RSL_US_PER_S))
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // per-rail condition levels from the sequencing engine
    input wire logic [NUM_RAILS-1:0] rail_en,
    input wire logic [NUM_RAILS-1:0] on_cond,
    input wire logic [NUM_RAILS-1:0] on_dep_wait,
    input wire logic [NUM_RAILS-1:0] on_dly_run,
    input wire logic [NUM_RAILS-1:0] off_dep_wait,
    input wire logic [NUM_RAILS-1:0] off_dly_run,
    input wire logic [NUM_RAILS-1:0] above_pg,
    input wire logic [NUM_RAILS-1:0] pg_zero,
    input wire logic [NUM_RAILS-1:0] rail_low,
    input wire logic [NUM_RAILS-1:0] off_unlimited,
    input wire logic [NUM_RAILS-1:0] fault_off,
    input wire logic [NUM_RAILS-1:0] retry_run,
    input wire logic [NUM_RAILS-1:0] fault_shut,
    input wire logic [NUM_RAILS-1:0] reseq_wait,
    // measurement stream of the analog rails
    input wire logic meas_valid,
    input wire logic [4:0] meas_rail,
    input wire logic [15:0] meas_value,
    // fault events and pins
    input wire logic fault_valid,
    input wire logic [4:0] fault_rail,
    input wire logic [2:0] fault_type,
    input wire logic [IO_W-1:0] io_pins,
    input wire logic pwr_down,
    // values restored at power-up
    input wire logic [2:0] addr_pins,
    input wire logic [15:0] boot_rst_cnt,
    input wire logic [31:0] boot_rtc,
    // eeprom writer
    output logic ee_wr_valid,
    output rsl_pkg::rsl_rec_type ee_wr_kind,
    output logic [7:0] ee_wr_word,
    output logic [63:0] ee_wr_data,
    input wire logic ee_wr_ready,
    // status
    output logic [6:0] bus_addr,
    output logic [NUM_RAILS*4-1:0] rail_code
);
    // snapshot of all codes and pins, split into eeprom words
    localparam int SNAP_BITS = NUM_RAILS * 4 + IO_W;
    localparam int SNAP_WORDS = (SNAP_BITS + 63) / 64;
    localparam int SNAP_W = SNAP_WORDS * 64;

    // refuse sizes the record formats cannot carry
    generate
        if (NUM_RAILS > 32 || NUM_RAILS < 1 || NUM_ANALOG > NUM_RAILS ||
            NUM_ANALOG < 1 || SNAP_WORDS > 255 || PEAK_HOLD_CYC == 0 ||
            RTC_TICK_CYC == 0) begin : g_bad
            $error("rsl_logger: unsupported parameter values");
        end
    endgenerate

    // whole state of the block
    typedef struct packed {
        rsl_pkg::rsl_rail_state_type [NUM_RAILS-1:0] codes;
        logic [NUM_RAILS-1:0][7:0] flt;
        logic [NUM_ANALOG-1:0][15:0] last_v;
        logic [NUM_ANALOG-1:0][15:0] ram_pk;
        logic [NUM_ANALOG-1:0][15:0] log_pk;
        logic [NUM_ANALOG-1:0] pend_pk;
        logic [31:0] pk_tmr;
        logic [31:0] rtc;
        logic [31:0] tick;
        logic [15:0] rst_cnt;
        logic pend_rc;
        logic snap_taken;
        logic snap_busy;
        logic [7:0] snap_idx;
        logic [SNAP_W-1:0] snap_vec;
        logic fpend;
        logic [63:0] f_rec;
        logic f_lost;
        logic rtc_pend;
        logic pd_q;
        logic booted;
        logic [6:0] taddr;
        logic ee_valid;
        rsl_pkg::rsl_rec_type ee_kind;
        logic [7:0] ee_word;
        logic [63:0] ee_data;
        logic [31:0] rd_data;
    } rsl_state_type;

    rsl_state_type st; // registered state
    rsl_state_type next_st; // next state
    rsl_pkg::rsl_rail_state_type [NUM_RAILS-1:0] next_code; // per rail

    // per-rail state code transitions
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RAILS; gi++) begin : g_rail
            logic was_on; // rail had been enabled before disable
            assign was_on = st.codes[gi] == rsl_pkg::RSL_RISING ||
                st.codes[gi] == rsl_pkg::RSL_REGULATED ||
                st.codes[gi] == rsl_pkg::RSL_AWAIT_OFF ||
                st.codes[gi] == rsl_pkg::RSL_OFF_DELAY ||
                st.codes[gi] == rsl_pkg::RSL_FALLING;
            always_comb begin
                if (off_dep_wait[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_AWAIT_OFF;
                end else if (off_dly_run[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_OFF_DELAY;
                end else if (rail_en[gi]) begin
                    if (st.codes[gi] == rsl_pkg::RSL_REGULATED) begin
                        // sticky even if voltage sags
                        next_code[gi] = rsl_pkg::RSL_REGULATED;
                    end else if (above_pg[gi] && !pg_zero[gi]) begin
                        next_code[gi] = rsl_pkg::RSL_REGULATED;
                    end else begin
                        // zero threshold never reaches regulated
                        next_code[gi] = rsl_pkg::RSL_RISING;
                    end
                end else if (was_on && !rail_low[gi] &&
                    (!off_unlimited[gi] || fault_off[gi]) &&
                    !retry_run[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_FALLING;
                end else if (fault_shut[gi] || reseq_wait[gi] ||
                    !on_cond[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_INACTIVE;
                end else if (on_dep_wait[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_AWAIT_ON;
                end else if (on_dly_run[gi]) begin
                    next_code[gi] = rsl_pkg::RSL_ON_DELAY;
                end else begin
                    next_code[gi] = rsl_pkg::RSL_INACTIVE;
                end
            end
        end
    endgenerate

    // all other next-state logic of the block
    always_comb begin
        int k; // register window index
        int pk; // lowest pending peak rail
        logic ee_free; // output record slot can take a new record
        logic [15:0] fv; // last voltage of the faulted rail
        k = 0;
        pk = -1;
        ee_free = !st.ee_valid || ee_wr_ready;
        fv = 16'h0000;
        next_st = st;

        // state codes move in the cycle of the transition
        next_st.codes = next_code;

        // run-time clock, host write overrides the tick
        if (st.tick + 32'h1 >= RTC_TICK_CYC) begin
            next_st.tick = 32'h0;
            next_st.rtc = st.rtc + 32'h1;
        end else begin
            next_st.tick = st.tick + 32'h1;
        end
        if (reg_wr && reg_addr == `RSL_A_RTC) begin
            next_st.rtc = reg_wdata;
            next_st.tick = 32'h0;
        end

        // one-time power-up capture after reset release
        if (!st.booted) begin
            next_st.booted = 1'b1;
            case (addr_pins)
                3'h0: next_st.taddr = `RSL_TADDR_0;
                3'h1: next_st.taddr = `RSL_TADDR_1;
                3'h2: next_st.taddr = `RSL_TADDR_2;
                3'h3: next_st.taddr = `RSL_TADDR_3;
                3'h4: next_st.taddr = `RSL_TADDR_4;
                3'h5: next_st.taddr = `RSL_TADDR_5;
                3'h6: next_st.taddr = `RSL_TADDR_6;
                default: next_st.taddr = `RSL_TADDR_7;
            endcase
            next_st.rst_cnt = boot_rst_cnt + 16'h1;
            next_st.pend_rc = 1'b1;
            next_st.rtc = boot_rtc;
        end

        // host clears the reset count
        if (reg_wr && reg_addr == `RSL_A_RSTCNT) begin
            next_st.rst_cnt = 16'h0000;
            next_st.pend_rc = 1'b1;
        end

        // power-down edge saves the run-time clock
        next_st.pd_q = pwr_down;
        if (pwr_down && !st.pd_q) begin
            next_st.rtc_pend = 1'b1;
        end

        // measurements: last voltage and running peak
        if (st.pk_tmr != 32'h0) begin
            next_st.pk_tmr = st.pk_tmr - 32'h1;
            if (st.pk_tmr == 32'h1) begin
                // interval over: flag rails whose peak rose
                for (int r = 0; r < NUM_ANALOG; r++) begin
                    if (st.ram_pk[r] > st.log_pk[r]) begin
                        next_st.pend_pk[r] = 1'b1;
                    end
                end
            end
        end
        if (meas_valid && 32'(meas_rail) < 32'(NUM_ANALOG)) begin
            next_st.last_v[meas_rail] = meas_value;
            if (meas_value > st.ram_pk[meas_rail]) begin
                next_st.ram_pk[meas_rail] = meas_value;
            end
            if (meas_value > st.log_pk[meas_rail] &&
                st.pk_tmr == 32'h0) begin
                next_st.pk_tmr = PEAK_HOLD_CYC;
            end
        end

        // host clears rail status bits by writing ones
        if (reg_wr && reg_addr >= `RSL_A_FLT &&
            reg_addr < `RSL_A_FLT + `RSL_N_FLT) begin
            k = int'(reg_addr - `RSL_A_FLT);
            for (int b = 0; b < 4; b++) begin
                if (k * 4 + b < NUM_RAILS) begin
                    next_st.flt[k * 4 + b] = st.flt[k * 4 + b] &
                        ~reg_wdata[b * 8 +: 8];
                end
            end
        end

        // host clears the lost flag, and the snapshot flag unless a snapshot is being written
        if (reg_wr && reg_addr == `RSL_A_SNAP) begin
            if (reg_wdata[`RSL_SNAP_TAKEN_BIT] && !st.snap_busy) begin
                next_st.snap_taken = 1'b0;
            end
            if (reg_wdata[`RSL_SNAP_LOST_BIT]) begin
                next_st.f_lost = 1'b0;
            end
        end

        // fault events: status bit, record and first snapshot
        if (fault_valid && 32'(fault_rail) < 32'(NUM_RAILS)) begin
            // set wins over a clear in the same cycle
            next_st.flt[fault_rail][fault_type] = 1'b1;
            if (32'(fault_rail) < 32'(NUM_ANALOG)) begin
                fv = st.last_v[fault_rail];
            end
            // a record handed over this cycle frees its slot
            if (st.fpend && !(ee_free && !st.snap_busy)) begin
                next_st.f_lost = 1'b1;
            end else begin
                next_st.fpend = 1'b1;
                next_st.f_rec = {8'h00, fault_rail, fault_type, st.rtc,
                    fv};
            end
            if (!st.snap_taken) begin
                next_st.snap_taken = 1'b1;
                next_st.snap_busy = 1'b1;
                next_st.snap_idx = 8'h00;
                next_st.snap_vec = SNAP_W'({io_pins, st.codes});
            end // a taken snapshot is left alone
        end

        // record slot: hand over, then refill by priority
        if (ee_free) begin
            next_st.ee_valid = 1'b0;
            next_st.ee_kind = rsl_pkg::RSL_REC_NONE;
            for (int r = NUM_ANALOG - 1; r >= 0; r--) begin
                if (st.pend_pk[r]) begin
                    pk = r;
                end
            end
            if (st.snap_busy) begin
                next_st.ee_valid = 1'b1;
                next_st.ee_kind = rsl_pkg::RSL_REC_SNAP;
                next_st.ee_word = st.snap_idx;
                next_st.ee_data = st.snap_vec[st.snap_idx * 64 +: 64];
                next_st.snap_idx = st.snap_idx + 8'h1;
                if (32'(st.snap_idx) == 32'(SNAP_WORDS - 1)) begin
                    next_st.snap_busy = 1'b0;
                end
            end else if (st.fpend) begin
                next_st.ee_valid = 1'b1;
                next_st.ee_kind = rsl_pkg::RSL_REC_FAULT;
                next_st.ee_word = 8'h00;
                next_st.ee_data = st.f_rec;
                next_st.fpend = fault_valid && st.fpend &&
                    32'(fault_rail) < 32'(NUM_RAILS);
            end else if (st.rtc_pend) begin
                next_st.ee_valid = 1'b1;
                next_st.ee_kind = rsl_pkg::RSL_REC_RTC;
                next_st.ee_word = 8'h00;
                next_st.ee_data = {32'h0, st.rtc};
                next_st.rtc_pend = pwr_down && !st.pd_q;
            end else if (st.pend_rc) begin
                next_st.ee_valid = 1'b1;
                next_st.ee_kind = rsl_pkg::RSL_REC_RSTCNT;
                next_st.ee_word = 8'h00;
                next_st.ee_data = {48'h0, st.rst_cnt};
                next_st.pend_rc = reg_wr && reg_addr == `RSL_A_RSTCNT;
            end else if (pk >= 0) begin
                // only the interval's highest value is written
                next_st.ee_valid = 1'b1;
                next_st.ee_kind = rsl_pkg::RSL_REC_PEAK;
                next_st.ee_word = 8'(pk);
                next_st.ee_data = {43'h0, 5'(pk), st.ram_pk[pk]};
                next_st.log_pk[pk] = st.ram_pk[pk];
                next_st.pend_pk[pk] = 1'b0;
            end
        end

        // read data appear the cycle after the strobe
        next_st.rd_data = 32'h0;
        if (reg_rd) begin
            if (reg_addr >= `RSL_A_STATE &&
                reg_addr < `RSL_A_STATE + `RSL_N_STATE) begin
                k = int'(reg_addr - `RSL_A_STATE);
                next_st.rd_data = 32'(128'(st.codes) >> (k * 32));
            end else if (reg_addr >= `RSL_A_FLT &&
                reg_addr < `RSL_A_FLT + `RSL_N_FLT) begin
                k = int'(reg_addr - `RSL_A_FLT);
                next_st.rd_data = 32'(256'(st.flt) >> (k * 32));
            end else if (reg_addr == `RSL_A_RTC) begin
                next_st.rd_data = st.rtc;
            end else if (reg_addr == `RSL_A_RSTCNT) begin
                next_st.rd_data = {16'h0, st.rst_cnt};
            end else if (reg_addr == `RSL_A_SNAP) begin
                next_st.rd_data[`RSL_SNAP_TAKEN_BIT] = st.snap_taken;
                next_st.rd_data[`RSL_SNAP_LOST_BIT] = st.f_lost;
                next_st.rd_data[`RSL_SNAP_BUSY_BIT] = st.snap_busy;
            end else if (reg_addr == `RSL_A_BUSADDR) begin
                next_st.rd_data = {25'h0, st.taddr};
            end else if (reg_addr >= `RSL_A_PEAK &&
                32'(reg_addr) < 32'(`RSL_A_PEAK) + 32'(NUM_ANALOG)) begin
                k = int'(reg_addr - `RSL_A_PEAK);
                next_st.rd_data = {16'h0, st.ram_pk[k]};
            end else if (reg_addr >= `RSL_A_VOLT &&
                32'(reg_addr) < 32'(`RSL_A_VOLT) + 32'(NUM_ANALOG)) begin
                k = int'(reg_addr - `RSL_A_VOLT);
                next_st.rd_data = {16'h0, st.last_v[k]};
            end
        end

        // synchronous reset: every field to its idle value
        if (sys_rst) begin
            next_st = '0;
            for (int r = 0; r < NUM_RAILS; r++) begin
                next_st.codes[r] = rsl_pkg::RSL_INACTIVE;
            end
        end
    end

    // single state register
    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    // outputs straight from the state register
    assign reg_rdata = st.rd_data;
    assign ee_wr_valid = st.ee_valid;
    assign ee_wr_kind = st.ee_kind;
    assign ee_wr_word = st.ee_word;
    assign ee_wr_data = st.ee_data;
    assign bus_addr = st.taddr;
    assign rail_code = st.codes;
endmodule // rsl_logger

/* rsl_logger_asserts.sv */
// port-level checks of the rail state and fault logger
// assumes binding onto rsl_logger; rail 0 carries the state checks
`timescale 1ns/1ps
`include "rsl_consts.svh"
module rsl_logger_asserts #(
    parameter int NUM_RAILS = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [6:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // rail conditions and address pins
    input wire logic [NUM_RAILS-1:0] rail_en,
    input wire logic [NUM_RAILS-1:0] off_dep_wait,
    input wire logic [NUM_RAILS-1:0] off_dly_run,
    input wire logic [NUM_RAILS-1:0] pg_zero,
    input wire logic [2:0] addr_pins,
    // eeprom writer
    input wire logic ee_wr_valid,
    input wire rsl_pkg::rsl_rec_type ee_wr_kind,
    input wire logic [7:0] ee_wr_word,
    input wire logic [63:0] ee_wr_data,
    input wire logic ee_wr_ready,
    // status
    input wire logic [6:0] bus_addr,
    input wire logic [NUM_RAILS*4-1:0] rail_code
);
    // decode table of the three address pins
    localparam logic [6:0] TADDR [8] = '{`RSL_TADDR_0, `RSL_TADDR_1,
        `RSL_TADDR_2, `RSL_TADDR_3, `RSL_TADDR_4, `RSL_TADDR_5,
        `RSL_TADDR_6, `RSL_TADDR_7};
    wire [3:0] code0 = rail_code[3:0]; // reported code of rail 0
    // rail 0 enabled with no turn-off step pending
    wire on_path = rail_en[0] && !off_dep_wait[0] && !off_dly_run[0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    boot_state_a: assert property ($fell(sys_rst) |->
        rail_code == {NUM_RAILS{4'h1}} && reg_rdata == 32'h0 && !ee_wr_valid)
        else $error("bad reset state");
    rdata_quiet_a: assert property (!$past(reg_rd) |->
        reg_rdata == 32'h0) else $error("stray read data");
    code_read_a: assert property (reg_rd && reg_addr == `RSL_A_STATE
        |=> reg_rdata == $past(rail_code[31:0]))
        else $error("bad state word");
    rec_hold_a: assert property (ee_wr_valid && !ee_wr_ready |=>
        ee_wr_valid && $stable(ee_wr_kind) && $stable(ee_wr_word)
        && $stable(ee_wr_data)) else $error("record moved");
    off_wait_a: assert property (off_dep_wait[0] |=> code0 == 4'h6)
        else $error("turn-off wait code wrong");
    off_delay_a: assert property (off_dly_run[0] && !off_dep_wait[0]
        |=> code0 == 4'h7) else $error("turn-off delay code wrong");
    zero_pg_a: assert property (on_path && pg_zero[0] && code0 != 4'h5
        |=> code0 == 4'h4) else $error("left rising");
    reg_hold_a: assert property (on_path && code0 == 4'h5
        |=> code0 == 4'h5) else $error("regulated state not held");
    addr_decode_a: assert property ($fell(sys_rst) |=>
        bus_addr == TADDR[$past(addr_pins)]) else $error("bad bus address");
    addr_fixed_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
        |-> $stable(bus_addr)) else $error("address moved");
    // main scenarios reached
    cover property (code0 == 4'h5);
    cover property (code0 == 4'h8);
    cover property (ee_wr_valid && !ee_wr_ready);
endmodule // rsl_logger_asserts

/* rsl_pkg.sv */
// types of the rail state and fault logger
// assumes rsl_consts.svh on the include path
package rsl_pkg;
`include "rsl_consts.svh"

    // reported state code of one rail
    typedef enum logic [3:0] {
        RSL_INACTIVE = `RSL_CODE_INACTIVE,
        RSL_AWAIT_ON = `RSL_CODE_AWAIT_ON,
        RSL_ON_DELAY = `RSL_CODE_ON_DELAY,
        RSL_RISING = `RSL_CODE_RISING,
        RSL_REGULATED = `RSL_CODE_REGULATED,
        RSL_AWAIT_OFF = `RSL_CODE_AWAIT_OFF,
        RSL_OFF_DELAY = `RSL_CODE_OFF_DELAY,
        RSL_FALLING = `RSL_CODE_FALLING
    } rsl_rail_state_type;

    // kind of record sent to the nonvolatile store
    typedef enum logic [2:0] {
        RSL_REC_NONE = 3'h0,
        RSL_REC_FAULT = 3'h1,
        RSL_REC_SNAP = 3'h3,
        RSL_REC_PEAK = 3'h2,
        RSL_REC_RTC = 3'h6,
        RSL_REC_RSTCNT = 3'h7
    } rsl_rec_type;
endpackage

/* tb_rsl_logger.sv */
// self-checking bench of the rail state and fault logger
// assumes rsl_ee_model as eeprom writer and the checker bound below
`timescale 1ns/1ps
`include "rsl_consts.svh"
module tb_rsl_logger;
    // rail 0 walk: code in bits 19:16, condition levels in 13:0
    localparam logic [19:0] STEP [17] = '{20'h10000, 20'h21800, 20'h31400,
        20'h420c0, 20'h52080, 20'h52000, 20'h60200, 20'h70100, 20'h80000,
        20'h10004, 20'h52080, 20'h10010, 20'h52080, 20'h80018, 20'h10020,
        20'h11801, 20'h11802};
    logic ref_clk, sys_rst, reg_wr, reg_rd, meas_valid, fault_valid;
    logic pwr_down, slow, ee_wr_valid, ee_wr_ready;
    logic [31:0] rail_en, on_cond, on_dep_wait, on_dly_run, off_dep_wait;
    logic [31:0] off_dly_run, above_pg, pg_zero, rail_low, off_unlimited;
    logic [31:0] fault_off, retry_run, fault_shut, reseq_wait;
    logic [31:0] reg_wdata, reg_rdata, boot_rtc;
    logic [6:0] reg_addr, bus_addr;
    logic [4:0] meas_rail, fault_rail;
    logic [15:0] meas_value, boot_rst_cnt;
    logic [2:0] fault_type, addr_pins;
    logic [83:0] io_pins;
    rsl_pkg::rsl_rec_type ee_wr_kind;
    logic [7:0] ee_wr_word;
    logic [63:0] ee_wr_data;
    logic [127:0] rail_code;
    int failures, n_checks;
    // short hold and tick for a brief run
    rsl_logger #(.PEAK_HOLD_CYC(32'h32), .RTC_TICK_CYC(32'h4)) dut (.*);
    rsl_ee_model ee (.*);
    // 8 ns clock
    always #4 ref_clk = ~ref_clk;
    // compare one value and count it
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle register strobes
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // one-cycle event pulses
    task automatic meas(input logic [4:0] r, input logic [15:0] v);
        @(posedge ref_clk);
        meas_valid <= 1'b1;
        meas_rail <= r;
        meas_value <= v;
        @(posedge ref_clk);
        meas_valid <= 1'b0;
    endtask
    task automatic fault(input logic [4:0] r, input logic [2:0] t);
        @(posedge ref_clk);
        fault_valid <= 1'b1;
        fault_rail <= r;
        fault_type <= t;
        @(posedge ref_clk);
        fault_valid <= 1'b0;
    endtask
    // wait for n records of one kind
    task automatic wait_cnt(input int k, input int n);
        for (int i = 0; i < 400 && ee.cnt[k] < n; i++) @(posedge ref_clk);
    endtask
    task automatic t_boot();
        logic [31:0] d;
        rd(`RSL_A_BUSADDR, d);
        chk(d, {25'h0, `RSL_TADDR_5});
        addr_pins <= 3'h2;
        rd(`RSL_A_BUSADDR, d);
        chk(d, {25'h0, `RSL_TADDR_5});
        rd(`RSL_A_RSTCNT, d);
        chk(d, 32'ha);
        wait_cnt(7, 1);
        chk(ee.last[7], 64'ha);
        rd(7'h7f, d);
        chk(d, 32'h0);
        $display("boot test done");
    endtask
    task automatic t_codes();
        logic [31:0] d;
        logic [3:0] e;
        for (int i = 0; i < 17; i++) begin
            @(posedge ref_clk);
            {rail_en[0], on_cond[0], on_dep_wait[0], on_dly_run[0],
                off_dep_wait[0], off_dly_run[0], above_pg[0], pg_zero[0],
                rail_low[0], off_unlimited[0], fault_off[0], retry_run[0],
                fault_shut[0], reseq_wait[0]} <= STEP[i][13:0];
            @(posedge ref_clk);
            #1;
            e = STEP[i][19:16];
            chk(rail_code[3:0], e);
            rd(`RSL_A_STATE, d);
            chk(d[3:0], e);
        end
        $display("rail code test done");
    endtask
    task automatic t_peak();
        time t0;
        logic [31:0] d;
        meas(5'h3, 16'h0500);
        t0 = $time;
        repeat (10) @(posedge ref_clk);
        meas(5'h3, 16'h0700);
        wait_cnt(2, 1);
        chk(($time - t0) >= 384 && ($time - t0) <= 480, 1'b1);
        chk(ee.last[2], {43'h0, 5'h3, 16'h0700});
        repeat (80) @(posedge ref_clk);
        chk(ee.cnt[2], 64'h1);
        rd(`RSL_A_PEAK + 7'h3, d);
        chk(d, 32'h0700);
        $display("peak test done");
    endtask
    task automatic t_fault();
        int s;
        logic [31:0] d;
        meas(5'h2, 16'h1234);
        slow <= 1'b1;
        fault(5'h2, 3'h3);
        wait_cnt(1, 1);
        s = ee.cnt[3];
        chk(s > 0, 1'b1);
        chk(ee.last[1][55:48], {5'h2, 3'h3});
        chk(ee.last[1][15:0], 16'h1234);
        fault(5'h1, 3'h0);
        wait_cnt(1, 2);
        chk(ee.cnt[3], s);
        rd(`RSL_A_FLT, d);
        chk(d, 32'h00080100);
        rd(`RSL_A_SNAP, d);
        chk(d, 32'h1);
        wr(`RSL_A_SNAP, 32'h1);
        wr(`RSL_A_FLT, 32'h00080100);
        rd(`RSL_A_FLT, d);
        chk(d, 32'h0);
        fault(5'h4, 3'h1);
        wait_cnt(1, 3);
        chk(ee.cnt[3] > s, 1'b1);
        slow <= 1'b0;
        $display("fault test done");
    endtask
    task automatic t_rtc();
        logic [31:0] d;
        wr(`RSL_A_RTC, 32'h00010000);
        rd(`RSL_A_RTC, d);
        chk(d >= 32'h00010000 && d <= 32'h00010001, 1'b1);
        pwr_down <= 1'b1;
        wait_cnt(6, 1);
        chk(ee.last[6][31:16], 16'h0001);
        wr(`RSL_A_RSTCNT, 32'h5);
        rd(`RSL_A_RSTCNT, d);
        chk(d, 32'h0);
        wait_cnt(7, 2);
        chk(ee.last[7], 64'h0);
        $display("clock test done");
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    // main sequence
    initial begin
        {ref_clk, reg_wr, reg_rd, meas_valid, fault_valid, pwr_down} = '0;
        {rail_en, on_cond, on_dep_wait, on_dly_run, off_dep_wait} = '0;
        {off_dly_run, above_pg, pg_zero, rail_low, off_unlimited} = '0;
        {fault_off, retry_run, fault_shut, reseq_wait, reg_wdata} = '0;
        {slow, reg_addr, meas_rail, fault_rail, meas_value, fault_type} = '0;
        {failures, n_checks} = '0;
        sys_rst = 1'b1;
        addr_pins = 3'h5;
        boot_rst_cnt = 16'h0009;
        boot_rtc = 32'h00000100;
        io_pins = 84'h5a5a5a5a5a5a5a5a5a5a5;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_boot();
        t_codes();
        t_peak();
        t_fault();
        t_rtc();
        print_verdict();
    end
endmodule // tb_rsl_logger
bind rsl_logger rsl_logger_asserts #(.NUM_RAILS(NUM_RAILS)) chk_i (.*);
